// ==== rtl/srsg_pkg.sv ====
/*
  Shared constants for the system reset and supply guard block.
  Assumes a single 50 MHz system clock and plain-port control.
*/
package srsg_pkg;
  // Clock rate and documented times.
  localparam int CLOCK_HZ          = 50_000_000;
  localparam int WAKE_COUNT_CYCLES = 4096;           // Fixed clock count before release.
  localparam int OSC_START_US      = 60;             // Oscillator start-up time.
  localparam int OSC_START_CYCLES  = (OSC_START_US * (CLOCK_HZ / 1_000_000));
  localparam int FLASH_INIT_US     = 100;            // Flash start-up time.
  localparam int FLASH_INIT_CYCLES = (FLASH_INIT_US * (CLOCK_HZ / 1_000_000));
  localparam int CNT_W             = 16;
  // Supply thresholds in millivolts, with hysteresis band.
  localparam logic [11:0] DROOP_IRQ_MV   = 12'hB86;  // 2950 mV.
  localparam logic [11:0] DROOP_RST_MV   = 12'hA5A;  // 2650 mV.
  localparam logic [11:0] DROOP_HYST_MV  = 12'h032;  // 50 mV.
  localparam logic [11:0] POR_LIMIT_MV   = 12'h3E8;  // 1000 mV.
  // Guard patterns read from the dedicated flash word.
  localparam logic [31:0] GUARD_ONE_PAT   = 32'h1234_5678;
  localparam logic [31:0] GUARD_TWO_PAT   = 32'h8765_4321;
  localparam logic [31:0] GUARD_THREE_PAT = 32'h4321_8765;
  // Vector map selections.
  localparam logic [1:0] MAP_BOOT  = 2'h0;
  localparam logic [1:0] MAP_SRAM  = 2'h1;
  localparam logic [1:0] MAP_EXT   = 2'h2;
  localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0000;
  // Clock source selections.
  localparam logic [1:0] CLK_RC    = 2'h0;
  localparam int EXT_IRQ_N         = 4;
  typedef enum logic [1:0] {GUARD_NONE, GUARD_ONE, GUARD_TWO, GUARD_THREE} srsg_guard_t;
  typedef enum {ST_HOLD, ST_OSC, ST_COUNT, ST_FLASH, ST_RUN} srsg_state_t;
endpackage

// ==== rtl/srsg_sync2.sv ====
/*
  Two-flop synchroniser for a vector of asynchronous levels.
  Assumes the destination clock is the system clock.
*/
`timescale 1ns/1ps
module srsg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,  // System clock.
  input  wire logic         rst_n,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] async,  // Asynchronous levels.
  output logic      [W-1:0] synced  // Synchronised levels.
);
  logic [W-1:0] stageOne;

  // Only the second flop reads the first.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stageOne <= '0;
      synced   <= '0;
    end else begin
      stageOne <= async;
      synced   <= stageOne;
    end
  end
endmodule

// ==== rtl/srsg_droop_cmp.sv ====
/*
  Supply comparator with hysteresis on a millivolt sample.
  Assumes the sample word is stable in the system clock domain.
*/
`timescale 1ns/1ps
module srsg_droop_cmp (
  input  wire logic        clock,     // System clock.
  input  wire logic        rst_n,     // Asynchronous reset, active low.
  input  wire logic [11:0] supplyMv,  // Sampled supply in millivolts.
  input  wire logic [11:0] threshMv,  // Trip threshold.
  output logic             below      // High while supply counts as low.
);
  // Trips below the threshold, clears only at or above threshold plus hysteresis.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      below <= 1'b1;
    end else if (supplyMv < threshMv) begin
      below <= 1'b1;
    end else if (supplyMv >= 12'(threshMv + srsg_pkg::DROOP_HYST_MV)) begin
      below <= 1'b0;
    end
  end
endmodule

// ==== rtl/srsg_top.sv ====
/*
  System reset and supply guard: merges reset sources, times the reset
  release, monitors the supply in two stages, applies guard levels and
  selects the vector map. Assumes pins are asynchronous and the supply
  sample word comes from an ADC-like monitor already held steady.
*/
// Behaviour
// - Four sources (pin, watchdog, power-on, supply droop) merge into one chip reset.
// - Any reset starts the wake-up timer and reset holds until pin release, oscillator, count and flash init.
// - On release the processor fetches address zero, mapped from the boot block.
// - Only rst_n clears every register; the other sources leave the droop and external interrupt registers running.
// - Supply below the first threshold raises an interrupt request.
// - That request is gated by its enable while its state stays readable for polling.
// - Supply below the second threshold forces chip reset.
// - Droop reset holds down to the lower limit where power-on reset takes over.
// - Both comparisons use hysteresis.
// - The guard level comes from a pattern in flash; in-application programming always works.
// - Level one blocks debug and allows limited loader updates excluding sector zero.
// - Level two blocks debug and allows only full erase and reprogram via the loader.
// - Level three blocks debug and the loader and ignores the boot override pin.
// - External interrupts are edge or level sensitive and may wake from power-down.
// - Vector mapping selects boot ROM, SRAM or external memory at address zero.
// - After power-up and deep wake-up the RC oscillator is the clock; others stay off.
`timescale 1ns/1ps
module srsg_top (
  input  wire logic        clock,           // System clock, 50 MHz.
  input  wire logic        rst_n,           // Power-on reset, active low.
  input  wire logic        resetPin_n,      // External reset pin, active low.
  input  wire logic        watchdogReset,   // Watchdog reset request.
  input  wire logic        oscRunning,      // Oscillator running indication.
  input  wire logic        flashInitDone,   // Flash controller init complete.
  input  wire logic [11:0] supplyMv,        // Core supply sample in millivolts.
  input  wire logic        droopIrqEnable,  // Droop interrupt enable.
  input  wire logic [31:0] guardWord,       // Dedicated flash guard pattern.
  input  wire logic        guardWordValid,  // Guard word has been read.
  input  wire logic        bootOverridePin, // Boot override pin level.
  input  wire logic [1:0]  vectorMapSel,    // Vector map selection.
  input  wire logic [srsg_pkg::EXT_IRQ_N-1:0] extIrqPin,  // External interrupt pins.
  input  wire logic [srsg_pkg::EXT_IRQ_N-1:0] extIrqEdge, // Per-pin edge mode when high.
  input  wire logic [srsg_pkg::EXT_IRQ_N-1:0] extWakeEn,  // Per-pin wake enable.
  input  wire logic        powerDown,       // Power-down mode active.
  input  wire logic        deepWake,        // Wake from deep low-power mode.
  input  wire logic [1:0]  clkSrcReq,       // Software clock source request.
  output logic             chipReset_n,     // Internal chip reset, active low.
  output logic             droopIrq,        // Gated droop interrupt request.
  output logic             droopStatus,     // Droop status for polling.
  output logic             debugAllow,      // Debug port allowed.
  output logic             loaderAllow,     // Programming loader allowed.
  output logic             loaderLimited,   // Loader limited to non-zero sectors.
  output logic             loaderFullOnly,  // Loader full erase only.
  output logic             enterLoader,     // Boot override honoured.
  output logic             iapAllow,        // In-application programming allowed.
  output logic [1:0]       vectorMap,       // Active vector map.
  output logic [31:0]      fetchAddr,       // First fetch address.
  output logic [srsg_pkg::EXT_IRQ_N-1:0] extIrq, // External interrupt requests.
  output logic             wakeUp,          // Wake request from power-down.
  output logic [1:0]       clkSrc           // Active clock source.
);
  localparam int EXT_N = srsg_pkg::EXT_IRQ_N;

  logic [4:0] syncIn;
  logic [EXT_N-1:0] extSync;
  logic pinRel, wdReq, oscOk, flashOk, bootPinS;
  logic belowIrq, belowRst, belowPor;
  logic [EXT_N-1:0] extPrev_reg;
  logic [srsg_pkg::CNT_W-1:0] count_reg, count_next;
  srsg_pkg::srsg_state_t state_reg, state_next;
  srsg_pkg::srsg_guard_t guard_reg;
  logic srcReset_n, relMeta_reg, rel_reg;

  // Asynchronous pins pass two flops first.
  srsg_sync2 #(.W(5)) uSyncCtl (
    .clock  (clock),
    .rst_n  (rst_n),
    .async  ({resetPin_n, watchdogReset, oscRunning, flashInitDone, bootOverridePin}),
    .synced (syncIn)
  );
  assign pinRel   = syncIn[4];
  assign wdReq    = syncIn[3];
  assign oscOk    = syncIn[2];
  assign flashOk  = syncIn[1];
  assign bootPinS = syncIn[0];

  srsg_sync2 #(.W(EXT_N)) uSyncExt (
    .clock  (clock),
    .rst_n  (rst_n),
    .async  (extIrqPin),
    .synced (extSync)
  );

  // Two-stage supply monitor, each with hysteresis.
  srsg_droop_cmp uCmpIrq (
    .clock    (clock),
    .rst_n    (rst_n),
    .supplyMv (supplyMv),
    .threshMv (srsg_pkg::DROOP_IRQ_MV),
    .below    (belowIrq)
  );
  srsg_droop_cmp uCmpRst (
    .clock    (clock),
    .rst_n    (rst_n),
    .supplyMv (supplyMv),
    .threshMv (srsg_pkg::DROOP_RST_MV),
    .below    (belowRst)
  );
  // Below the lower limit the power-on reset port is expected to be asserted.
  assign belowPor = (supplyMv < srsg_pkg::POR_LIMIT_MV);

  // Any source restarts the release sequence; rst_n is the power-on source.
  assign srcReset_n = pinRel & ~wdReq & ~belowRst & ~belowPor;

  // Wake-up sequencer: oscillator, fixed count, then flash init.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      srsg_pkg::ST_HOLD: begin
        count_next = '0;
        if (srcReset_n) state_next = srsg_pkg::ST_OSC;
      end
      srsg_pkg::ST_OSC: begin
        if (oscOk) state_next = srsg_pkg::ST_COUNT;
      end
      srsg_pkg::ST_COUNT: begin
        count_next = count_reg + 1'b1;
        if (count_reg == srsg_pkg::CNT_W'(srsg_pkg::WAKE_COUNT_CYCLES - 1)) begin
          state_next = srsg_pkg::ST_FLASH;
        end
      end
      srsg_pkg::ST_FLASH: begin
        if (flashOk) state_next = srsg_pkg::ST_RUN;
      end
      srsg_pkg::ST_RUN: ;
      default: state_next = srsg_pkg::ST_HOLD;
    endcase
    if (!srcReset_n) state_next = srsg_pkg::ST_HOLD;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= srsg_pkg::ST_HOLD;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Reset release passes a flop pair; assertion clears it at once.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      relMeta_reg <= 1'b0;
      rel_reg     <= 1'b0;
    end else if (state_next != srsg_pkg::ST_RUN) begin
      relMeta_reg <= 1'b0;
      rel_reg     <= 1'b0;
    end else begin
      relMeta_reg <= 1'b1;
      rel_reg     <= relMeta_reg;
    end
  end

  // Chip reset output comes from a flop; held low until the whole sequence ends.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) chipReset_n <= 1'b0;
    else chipReset_n <= rel_reg & (state_next == srsg_pkg::ST_RUN);
  end

  // Droop interrupt, gated by enable; status always visible.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      droopIrq    <= 1'b0;
      droopStatus <= 1'b0;
    end else begin
      droopStatus <= belowIrq;
      droopIrq    <= belowIrq & droopIrqEnable;
    end
  end

  // Guard level latched from flash while the chip is held in reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg <= srsg_pkg::GUARD_NONE;
    end else if (!chipReset_n && guardWordValid) begin
      case (guardWord)
        srsg_pkg::GUARD_ONE_PAT:   guard_reg <= srsg_pkg::GUARD_ONE;
        srsg_pkg::GUARD_TWO_PAT:   guard_reg <= srsg_pkg::GUARD_TWO;
        srsg_pkg::GUARD_THREE_PAT: guard_reg <= srsg_pkg::GUARD_THREE;
        default:                   guard_reg <= srsg_pkg::GUARD_NONE;
      endcase
    end
  end

  // Access gating derived from the guard level.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debugAllow     <= 1'b0;
      loaderAllow    <= 1'b0;
      loaderLimited  <= 1'b0;
      loaderFullOnly <= 1'b0;
      enterLoader    <= 1'b0;
      iapAllow       <= 1'b0;
    end else begin
      iapAllow       <= 1'b1;
      debugAllow     <= (guard_reg == srsg_pkg::GUARD_NONE);
      loaderAllow    <= (guard_reg != srsg_pkg::GUARD_THREE);
      loaderLimited  <= (guard_reg == srsg_pkg::GUARD_ONE);
      loaderFullOnly <= (guard_reg == srsg_pkg::GUARD_TWO);
      enterLoader    <= bootPinS & (guard_reg != srsg_pkg::GUARD_THREE);
    end
  end

  // Vector map: boot block during reset, then software choice.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vectorMap <= srsg_pkg::MAP_BOOT;
      fetchAddr <= srsg_pkg::RESET_VECTOR_ADDR;
    end else begin
      fetchAddr <= srsg_pkg::RESET_VECTOR_ADDR;
      if (!chipReset_n) vectorMap <= srsg_pkg::MAP_BOOT;
      else if (vectorMapSel == srsg_pkg::MAP_SRAM || vectorMapSel == srsg_pkg::MAP_EXT ||
               vectorMapSel == srsg_pkg::MAP_BOOT) vectorMap <= vectorMapSel;
    end
  end

  // External interrupts: edge or level per pin, optional wake.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_reg <= '0;
      extIrq      <= '0;
      wakeUp      <= 1'b0;
    end else begin
      extPrev_reg <= extSync;
      extIrq      <= (extIrqEdge & extSync & ~extPrev_reg) | (~extIrqEdge & extSync);
      wakeUp      <= powerDown & |(extSync & extWakeEn);
    end
  end

  // Clock source: RC after reset or deep wake, else software choice.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) clkSrc <= srsg_pkg::CLK_RC;
    else if (!chipReset_n || deepWake) clkSrc <= srsg_pkg::CLK_RC;
    else clkSrc <= clkSrcReq;
  end

  // Checks.
  chk_release_needs_run: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(chipReset_n) |-> $past(state_reg == srsg_pkg::ST_RUN))
    else $error("Reset released before sequence end.");
  chk_droop_forces_reset: assert property (@(posedge clock) disable iff (!rst_n)
    belowRst |-> ##[1:3] !chipReset_n)
    else $error("Droop did not force reset.");
  chk_wd_forces_reset: assert property (@(posedge clock) disable iff (!rst_n)
    wdReq |-> ##[1:2] !chipReset_n)
    else $error("Watchdog did not force reset.");
  chk_irq_gated: assert property (@(posedge clock) disable iff (!rst_n)
    droopIrq |-> droopStatus)
    else $error("Interrupt without status.");
  chk_status_follows: assert property (@(posedge clock) disable iff (!rst_n)
    belowIrq |=> droopStatus)
    else $error("Status missed droop.");
  chk_guard_three_loader: assert property (@(posedge clock) disable iff (!rst_n)
    (guard_reg == srsg_pkg::GUARD_THREE) |=> !enterLoader && !loaderAllow)
    else $error("Level three allowed loader.");
  chk_guard_debug_block: assert property (@(posedge clock) disable iff (!rst_n)
    (guard_reg != srsg_pkg::GUARD_NONE) |=> !debugAllow)
    else $error("Guarded debug allowed.");
  chk_map_boot_reset: assert property (@(posedge clock) disable iff (!rst_n)
    !chipReset_n |=> vectorMap == srsg_pkg::MAP_BOOT)
    else $error("Map not boot during reset.");
  chk_clk_rc_reset: assert property (@(posedge clock) disable iff (!rst_n)
    (!chipReset_n || deepWake) |=> clkSrc == srsg_pkg::CLK_RC)
    else $error("Clock not RC after reset.");
  chk_count_length: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == srsg_pkg::ST_COUNT) |-> count_reg < srsg_pkg::CNT_W'(srsg_pkg::WAKE_COUNT_CYCLES))
    else $error("Wake count overran.");

  // Further checks on reset sources, release order, interrupt enable, access gating and the first fetch.
  chk_pin_forces_reset: assert property (@(posedge clock) disable iff (!rst_n)
    !pinRel |-> ##[1:2] !chipReset_n)
    else $error("Pin did not force reset.");
  chk_por_holds_reset: assert property (@(posedge clock) disable iff (!rst_n)
    belowPor |=> !chipReset_n)
    else $error("Reset released below the lower limit.");
  chk_irq_needs_enable: assert property (@(posedge clock) disable iff (!rst_n)
    !droopIrqEnable |=> !droopIrq)
    else $error("Interrupt raised while disabled.");
  chk_iap_always_on: assert property (@(posedge clock) disable iff (!rst_n)
    chipReset_n |-> iapAllow)
    else $error("In-application programming blocked.");
  chk_level_one_access: assert property (@(posedge clock) disable iff (!rst_n)
    (guard_reg == srsg_pkg::GUARD_ONE) |=> loaderLimited && loaderAllow && !loaderFullOnly)
    else $error("Level one loader gating wrong.");
  chk_level_two_access: assert property (@(posedge clock) disable iff (!rst_n)
    (guard_reg == srsg_pkg::GUARD_TWO) |=> loaderFullOnly && loaderAllow && !loaderLimited)
    else $error("Level two loader gating wrong.");
  chk_fetch_at_zero: assert property (@(posedge clock) disable iff (!rst_n)
    chipReset_n |-> fetchAddr == srsg_pkg::RESET_VECTOR_ADDR)
    else $error("First fetch not at address zero.");
  chk_release_after_run: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg != srsg_pkg::ST_RUN) |=> !chipReset_n)
    else $error("Reset released outside the run state.");
  cov_por_band: cover property (@(posedge clock) disable iff (!rst_n) belowPor);
  cov_release: cover property (@(posedge clock) disable iff (!rst_n) $rose(chipReset_n));
  cov_droop_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(droopIrq));
  cov_guard_three: cover property (@(posedge clock) disable iff (!rst_n)
    guard_reg == srsg_pkg::GUARD_THREE);
  cov_wake: cover property (@(posedge clock) disable iff (!rst_n) wakeUp);
endmodule

// ==== testbench/srsg_far_side.sv ====
/*
  Far-side model: external reset pin, core supply monitor and the
  interrupt controller that receives the droop request.
  Assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/1ps
module srsg_far_side (
  input  wire logic   clock,          // System clock.
  input  wire logic   droopIrq,       // Gated droop request from the block.
  output logic        resetPin_n,     // External reset pin, active low.
  output logic [11:0] supplyMv,       // Core supply sample in millivolts.
  output logic        droopIrqEnable, // Controller enable for the droop line.
  output int          irqSeen         // Cycles in which the controller saw the request.
);
  // The pin starts low, so the chip is held in reset until the bench releases it.
  initial begin
    resetPin_n     = 1'b0;
    supplyMv       = 12'h0CE4;
    droopIrqEnable = 1'b0;
    irqSeen        = 0;
  end

  task automatic set_pin(input logic v);
    resetPin_n = v;
  endtask

  task automatic set_supply(input logic [11:0] mv);
    supplyMv = mv;
  endtask

  task automatic set_enable(input logic v);
    droopIrqEnable = v;
  endtask

  // The controller counts every cycle in which the request line is up.
  always @(posedge clock) begin
    if (droopIrq === 1'b1) begin
      irqSeen <= irqSeen + 1;
    end
  end
endmodule

// ==== testbench/system_reset_and_supply_guard_bench.sv ====
/*
  Self-checking bench for the reset and supply guard block.
  Assumes the design package is compiled first and a 50 MHz clock.
*/
`timescale 1ns/1ps
module system_reset_and_supply_guard_bench;
  logic        clock = 1'b0, rst_n = 1'b0, watchdogReset = 1'b0;
  logic        oscRunning = 1'b0, flashInitDone = 1'b0, guardWordValid = 1'b1;
  logic        bootOverridePin = 1'b1, powerDown = 1'b0, deepWake = 1'b0;
  logic [31:0] guardWord = 32'h0000_0000;
  logic [1:0]  vectorMapSel = 2'h0, clkSrcReq = 2'h0, vectorMap, clkSrc, expMap;
  logic [3:0]  extIrqPin = 4'h0, extIrqEdge = 4'h0, extWakeEn = 4'h0, extIrq;
  logic        resetPin_n, droopIrqEnable, chipReset_n, droopIrq, droopStatus;
  logic        debugAllow, loaderAllow, loaderLimited, loaderFullOnly;
  logic        enterLoader, iapAllow, wakeUp;
  logic [11:0] supplyMv;
  logic [31:0] fetchAddr;
  logic [31:0] guardPat [4] = '{32'h0000_0000, srsg_pkg::GUARD_ONE_PAT,
                                srsg_pkg::GUARD_TWO_PAT, srsg_pkg::GUARD_THREE_PAT};
  logic [5:0]  guardExp [4] = '{6'h33, 6'h1B, 6'h17, 6'h01};
  int          n_errors = 0, n_tests = 0, cyc = 0, irqSeen;

  srsg_top dut (.clock(clock), .rst_n(rst_n), .resetPin_n(resetPin_n),
    .watchdogReset(watchdogReset), .oscRunning(oscRunning), .flashInitDone(flashInitDone),
    .supplyMv(supplyMv), .droopIrqEnable(droopIrqEnable), .guardWord(guardWord),
    .guardWordValid(guardWordValid), .bootOverridePin(bootOverridePin),
    .vectorMapSel(vectorMapSel), .extIrqPin(extIrqPin), .extIrqEdge(extIrqEdge),
    .extWakeEn(extWakeEn), .powerDown(powerDown), .deepWake(deepWake),
    .clkSrcReq(clkSrcReq), .chipReset_n(chipReset_n), .droopIrq(droopIrq),
    .droopStatus(droopStatus), .debugAllow(debugAllow), .loaderAllow(loaderAllow),
    .loaderLimited(loaderLimited), .loaderFullOnly(loaderFullOnly),
    .enterLoader(enterLoader), .iapAllow(iapAllow), .vectorMap(vectorMap),
    .fetchAddr(fetchAddr), .extIrq(extIrq), .wakeUp(wakeUp), .clkSrc(clkSrc));

  srsg_far_side far (.clock(clock), .droopIrq(droopIrq), .resetPin_n(resetPin_n),
    .supplyMv(supplyMv), .droopIrqEnable(droopIrqEnable), .irqSeen(irqSeen));

  // The clock toggles every half period of 10 ns.
  always #10 clock = ~clock;

  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Holds the oscillator off, then times the release from its start.
  task automatic run_up;
    oscRunning = 1'b0;
    flashInitDone = 1'b0;
    ticks(100);
    chk("held without oscillator", 1'b0, chipReset_n);
    oscRunning = 1'b1;
    flashInitDone = 1'b1;
    cyc = 0;
    while (chipReset_n !== 1'b1 && cyc < 5000) begin
      ticks(1);
      cyc++;
    end
    chk("release span in range", 1'b1, cyc >= 4096 && cyc <= 4120);
  endtask

  // A short watchdog request must pull the chip reset down quickly.
  task automatic dog_reset;
    watchdogReset = 1'b1;
    ticks(4);
    chk("watchdog reset", 1'b0, chipReset_n);
    watchdogReset = 1'b0;
  endtask

  // The run is cut short if the tests take far longer than expected.
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial begin
    ticks(4);
    chk("outputs in reset", 32'h0000_0000, {chipReset_n, droopIrq, debugAllow, iapAllow,
        wakeUp, vectorMap, clkSrc, fetchAddr[22:0]});
    rst_n = 1'b1;
    ticks(50);
    chk("held by pin", 1'b0, chipReset_n);
    far.set_pin(1'b1);
    run_up();
    chk("first fetch", srsg_pkg::RESET_VECTOR_ADDR, fetchAddr);
    chk("clock source", srsg_pkg::CLK_RC, clkSrc);
    chk("boot map", srsg_pkg::MAP_BOOT, vectorMap);
    // Each guard pattern is taken during a reset and applied after it.
    for (int i = 0; i < 4; i++) begin
      guardWord = guardPat[i];
      dog_reset();
      run_up();
      chk("guard outputs", guardExp[i], {debugAllow, loaderAllow, loaderLimited,
          loaderFullOnly, enterLoader, iapAllow});
    end
    guardWord = 32'h0000_0000;
    ticks(5);
    chk("guard ignored in run", 6'h01, {debugAllow, loaderAllow, loaderLimited,
        loaderFullOnly, enterLoader, iapAllow});
    // First droop stage, gated and polled, with hysteresis.
    far.set_supply(12'h0B54);
    ticks(4);
    chk("droop status", 1'b1, droopStatus);
    chk("droop gated", 1'b0, droopIrq);
    far.set_enable(1'b1);
    ticks(3);
    chk("droop request", 1'b1, droopIrq);
    far.set_supply(12'h0B90);
    ticks(4);
    chk("droop hysteresis", 1'b1, droopStatus);
    far.set_supply(12'h0C1C);
    ticks(4);
    chk("droop cleared", 2'h0, {droopStatus, droopIrq});
    chk("controller saw request", 1'b1, irqSeen > 0);
    // Second droop stage forces reset and holds it within the band; a guard
    // word offered without its valid flag must be refused meanwhile.
    guardWordValid = 1'b0;
    guardWord = srsg_pkg::GUARD_ONE_PAT;
    far.set_supply(12'h0A28);
    ticks(4);
    chk("droop reset", 1'b0, chipReset_n);
    far.set_supply(12'h03B6);
    ticks(4);
    chk("power-on band reset", 1'b0, chipReset_n);
    far.set_supply(12'h0A78);
    ticks(20);
    chk("droop reset held", 1'b0, chipReset_n);
    far.set_supply(12'h0CE4);
    run_up();
    chk("guard word refused", 6'h01, {debugAllow, loaderAllow, loaderLimited,
        loaderFullOnly, enterLoader, iapAllow});
    // Pin reset holds as long as the pin is low; level one is taken then,
    // with the boot override pin low.
    guardWordValid = 1'b1;
    bootOverridePin = 1'b0;
    far.set_pin(1'b0);
    ticks(200);
    chk("pin reset held", 1'b0, chipReset_n);
    far.set_pin(1'b1);
    run_up();
    chk("level one no override", 6'h19, {debugAllow, loaderAllow, loaderLimited,
        loaderFullOnly, enterLoader, iapAllow});
    // Every map code, the unused code keeping the previous map.
    for (int s = 0; s < 4; s++) begin
      vectorMapSel = s[1:0];
      expMap = (s == 3) ? srsg_pkg::MAP_EXT : s[1:0];
      ticks(4);
      chk("vector map", expMap, vectorMap);
    end
    // Software clock choice is followed until a deep wake forces the RC source.
    clkSrcReq = 2'h2;
    ticks(3);
    chk("software clock source", 2'h2, clkSrc);
    deepWake = 1'b1;
    ticks(3);
    chk("clock after deep wake", srsg_pkg::CLK_RC, clkSrc);
    deepWake = 1'b0;
    // Level, edge and wake behaviour of the external interrupts.
    extIrqPin = 4'h1;
    ticks(5);
    chk("level irq", 4'h1, extIrq);
    extIrqPin = 4'h0;
    extIrqEdge = 4'h2;
    ticks(5);
    extIrqPin = 4'h2;
    cyc = 0;
    repeat (10) begin
      ticks(1);
      if (extIrq[1] === 1'b1) cyc++;
    end
    chk("edge pulse cycles", 1, cyc);
    powerDown = 1'b1;
    extWakeEn = 4'h4;
    extIrqPin = 4'h4;
    ticks(5);
    chk("wake from power-down", 1'b1, wakeUp);
    // Assertion of reset takes effect without waiting for a clock edge.
    rst_n = 1'b0;
    #1;
    chk("async assertion", 1'b0, chipReset_n);
    give_verdict();
  end
endmodule
